// ===== include/rgp_defines.svh
/*
 * Constants of the resonant gate protection block: offsets, field
 * positions, reset values and timing counts.
 * Assumes a 50 MHz mclk and byte addresses on the register port.
 */
// Operation
// - polarity flags come from two reference comparators
// - low-side off with negative flag is inductive
// - high-side off with positive flag is inductive
// - wrong flag at turn-off blocks opposite gate
// - capacitive wait holds dead time, freezes oscillator
// - after recovery, turn on only on slew
// - polarity timeout forces opposite gate on
// - discharge soft start after max dead time
// - first low-side turn-off restarts soft start
// - regulation crossing discharges soft start 10us minimum
// - regulation crossing starts timer charging
// - current drop before boost level resumes normal
// - past boost full discharge, stop level gates off
// - restart once timer decays to restart level
// - shutdown level discharges, latches at soft-start level
// - drop below regulation abandons shutdown path
// - latch holds until supply lockout
// - first-level overcurrent retries as hiccup
`ifndef RGP_DEFINES_SVH
`define RGP_DEFINES_SVH

// ********************************************************************
// register map (byte addresses)
// ********************************************************************
`define RGP_ADDR_CTRL      4'h0
`define RGP_ADDR_STATUS    4'h4
`define RGP_ADDR_MASK      4'h8
`define RGP_ADDR_STATE     4'hC

// field positions
`define RGP_CTRL_ENABLE    0
`define RGP_EV_CAPACITIVE  0
`define RGP_EV_OVERCURRENT 1
`define RGP_EV_TIMER_STOP  2
`define RGP_EV_LATCH       3

// reset values
`define RGP_CTRL_RESET     1'h1
`define RGP_MASK_RESET     4'h0

// ********************************************************************
// timing
// ********************************************************************
`define RGP_CLK_PERIOD_NS  20
`define RGP_MAX_DEAD_NS    1500
`define RGP_OC_MIN_NS      10000
`define RGP_POL_WAIT_NS    50000
`define RGP_MAX_DEAD_CYC   ((`RGP_MAX_DEAD_NS + `RGP_CLK_PERIOD_NS - 1) / `RGP_CLK_PERIOD_NS)
`define RGP_OC_MIN_CYC     ((`RGP_OC_MIN_NS + `RGP_CLK_PERIOD_NS - 1) / `RGP_CLK_PERIOD_NS)
`define RGP_POL_WAIT_CYC   (`RGP_POL_WAIT_NS / `RGP_CLK_PERIOD_NS)

`endif

// ===== include/rgp_pkg.sv
/*
 * Types of the resonant gate protection block: state encodings, the
 * comparator bundle, the drive bundle and the whole state record.
 * Assumes nothing of its surroundings.
 */
package rgp_pkg;

   // gate sequencer states, one-hot
   typedef enum logic [6:0] {
      G_OFF    = 7'h01,
      G_LOW_ON = 7'h02,
      G_DEAD_LH = 7'h04,
      G_HIGH_ON = 7'h08,
      G_DEAD_HL = 7'h10,
      G_CAP_LH = 7'h20,
      G_CAP_HL = 7'h40
   } rgp_gate_t;

   // overcurrent supervisor states, one-hot
   typedef enum logic [5:0] {
      OC_IDLE   = 6'h01,
      OC_REG    = 6'h02,
      OC_BOOST  = 6'h04,
      OC_STOP   = 6'h08,
      OC_SECOND = 6'h10,
      OC_LATCH  = 6'h20
   } rgp_oc_t;

   // synchronous comparator and oscillator inputs
   typedef struct packed {
      logic posRefAbove;       // current above positive reference
      logic negRefBelow;       // current below negative reference
      logic aboveRegulation;   // current above regulation_threshold
      logic aboveShutdown;     // current above shutdown_current_threshold
      logic timerAboveBoost;   // timer ramp above timer_boost_level
      logic timerAboveStop;    // timer ramp above timer_stop_level
      logic timerBelowRestart; // timer ramp below timer_restart_level
      logic ssBelowLatch;      // soft start below softstart_latch_level
      logic slewSense;         // switch_node slew seen on slew_sense_input
      logic supplyLockout;     // supply below supply_lockout
      logic oscHalfEnd;        // one-cycle pulse: half period finished
   } rgp_sense_t;

   // single-bit drives toward the power stage
   typedef struct packed {
      logic highSideGate;
      logic lowSideGate;
      logic deadTimeFlag;
      logic oscFreeze;
      logic ssDischarge;
      logic timerCharge;
      logic latchedOff;
      logic capacitiveGuard;
   } rgp_drive_t;

   // complete state of the block
   typedef struct packed {
      rgp_gate_t   gate;
      rgp_oc_t     oc;
      logic [11:0] deadCnt;
      logic [11:0] blankCnt;
      logic        blankRun;
      logic        polOk;
      logic        cmpDischarge;
      logic [9:0]  ocMinCnt;
      logic        enable;
      logic [3:0]  status;
      logic [3:0]  mask;
      logic        irq;
      logic [31:0] rdata;
      rgp_drive_t  drv;
   } rgp_state_t;

endpackage

// ===== verilog/rgp_protection.sv
/*
 * Protection sequencer of a resonant half-bridge gate controller:
 * capacitive guard at each gate turn-off, two-level overcurrent
 * with hiccup retry and latch, and a register port with one irq.
 * Sticky events are cleared by writing ones.
 * Assumes synchronous inputs, filtered comparators
 * and an oscillator that stops while oscFreeze is high.
 */
`timescale 1ns/1ps
`include "rgp_defines.svh"

module rgp_protection
(
   // clock, reset, enable
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              clkEn,
   // register port
   input  wire logic [3:0]        regAddr,
   input  wire logic [31:0]       regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic [31:0]            regRdata,
   // analog side
   input  wire rgp_pkg::rgp_sense_t sense,
   output rgp_pkg::rgp_drive_t    drive,
   // interrupt
   output logic                   irq
);

   // ******************************************************************
   // constants
   // ******************************************************************
   localparam logic [11:0] MaxDeadLast = 12'(`RGP_MAX_DEAD_CYC - 1);  // last dead-time cycle
   localparam logic [11:0] PolWaitLast = 12'(`RGP_POL_WAIT_CYC - 1);  // last polarity-wait cycle
   localparam logic [9:0]  OcMinLast   = 10'(`RGP_OC_MIN_CYC - 1);    // last minimum discharge cycle

   // ******************************************************************
   // state
   // ******************************************************************
   rgp_pkg::rgp_state_t state_reg;   // registered state
   rgp_pkg::rgp_state_t state_next;  // next state

   // outputs come straight from the state flops
   assign regRdata = state_reg.rdata;
   assign drive    = state_reg.drv;
   assign irq      = state_reg.irq;

   // ******************************************************************
   // next-state logic
   // ******************************************************************
   always_comb
   begin
      logic       posFlag;       // current_positive_flag
      logic       negFlag;       // current_negative_flag
      logic       gatesAllowed;  // switching permitted this cycle
      logic [3:0] events;        // events raised this cycle
      logic [3:0] clears;        // write-one-to-clear mask
      logic       expected;      // expected polarity in a capacitive wait
      logic       ocDischarge;   // overcurrent wants soft start discharged
      posFlag      = 1'b0;
      negFlag      = 1'b0;
      gatesAllowed = 1'b0;
      events       = 4'h0;
      clears       = 4'h0;
      expected     = 1'b0;
      ocDischarge  = 1'b0;
      state_next   = state_reg;
      state_next.rdata = 32'h0000_0000;

      // polarity flags from the two reference comparators
      posFlag = sense.posRefAbove;
      negFlag = sense.negRefBelow;

      // timer stop, latch and lockout all silence the gates
      gatesAllowed = state_reg.enable && !sense.supplyLockout
                     && (state_reg.oc != rgp_pkg::OC_STOP)
                     && (state_reg.oc != rgp_pkg::OC_LATCH);

      // blanking before soft-start discharge after a capacitive event
      if (state_reg.blankRun)
      begin
         if (state_reg.blankCnt == MaxDeadLast)
         begin
            state_next.blankRun     = 1'b0;
            state_next.cmpDischarge = 1'b1;
         end
         else
         begin
            state_next.blankCnt = state_reg.blankCnt + 12'h001;
         end
      end

      // ***************************************************************
      // gate sequencer
      // ***************************************************************
      unique case (state_reg.gate)
         rgp_pkg::G_OFF:
         begin
            // restart always on the low side so the bootstrap recharges
            if (gatesAllowed)
            begin
               state_next.gate             = rgp_pkg::G_LOW_ON;
               state_next.drv.lowSideGate  = 1'b1;
               state_next.drv.deadTimeFlag = 1'b0;
            end
         end
         rgp_pkg::G_LOW_ON,
         rgp_pkg::G_HIGH_ON:
         begin
            if (!gatesAllowed)
            begin
               state_next.gate = rgp_pkg::G_OFF;
            end
            else if (sense.oscHalfEnd)
            begin
               state_next.drv.lowSideGate  = 1'b0;
               state_next.drv.highSideGate = 1'b0;
               state_next.drv.deadTimeFlag = 1'b1;
               state_next.deadCnt          = 12'h000;
               state_next.polOk            = 1'b0;
               if (state_reg.gate == rgp_pkg::G_LOW_ON)
               begin
                  // low-side turn-off ends any capacitive discharge
                  state_next.cmpDischarge = 1'b0;
                  state_next.blankRun     = 1'b0;
                  if (negFlag)
                     state_next.gate = rgp_pkg::G_DEAD_LH;
                  else
                     state_next.gate = rgp_pkg::G_CAP_LH;
               end
               else
               begin
                  if (posFlag)
                     state_next.gate = rgp_pkg::G_DEAD_HL;
                  else
                     state_next.gate = rgp_pkg::G_CAP_HL;
               end
               // wrong polarity: hold dead time, stop the ramp, arm blanking
               if ((state_reg.gate == rgp_pkg::G_LOW_ON && !negFlag)
                   || (state_reg.gate == rgp_pkg::G_HIGH_ON && !posFlag))
               begin
                  state_next.drv.oscFreeze       = 1'b1;
                  state_next.drv.capacitiveGuard = 1'b1;
                  state_next.blankRun            = 1'b1;
                  state_next.blankCnt            = 12'h000;
                  events[`RGP_EV_CAPACITIVE]     = 1'b1;
               end
            end
         end
         rgp_pkg::G_DEAD_LH,
         rgp_pkg::G_DEAD_HL:
         begin
            // normal dead time: end on slew, or at max_dead_time
            state_next.deadCnt = state_reg.deadCnt + 12'h001;
            if (!gatesAllowed)
            begin
               state_next.gate = rgp_pkg::G_OFF;
            end
            else if (sense.slewSense || state_reg.deadCnt == MaxDeadLast)
            begin
               state_next.drv.deadTimeFlag = 1'b0;
               if (state_reg.gate == rgp_pkg::G_DEAD_LH)
               begin
                  state_next.gate             = rgp_pkg::G_HIGH_ON;
                  state_next.drv.highSideGate = 1'b1;
               end
               else
               begin
                  state_next.gate            = rgp_pkg::G_LOW_ON;
                  state_next.drv.lowSideGate = 1'b1;
               end
            end
         end
         rgp_pkg::G_CAP_LH,
         rgp_pkg::G_CAP_HL:
         begin
            // polarity recovers when the expected flag shows up
            expected = (state_reg.gate == rgp_pkg::G_CAP_LH) ? negFlag : posFlag;
            state_next.deadCnt = state_reg.deadCnt + 12'h001;
            if (expected)
               state_next.polOk = 1'b1;
            if (!gatesAllowed)
            begin
               state_next.gate = rgp_pkg::G_OFF;
            end
            else if (((state_reg.polOk || expected) && sense.slewSense)
                     || state_reg.deadCnt == PolWaitLast)
            begin
               state_next.drv.deadTimeFlag    = 1'b0;
               state_next.drv.oscFreeze       = 1'b0;
               state_next.drv.capacitiveGuard = 1'b0;
               if (state_reg.gate == rgp_pkg::G_CAP_LH)
               begin
                  state_next.gate             = rgp_pkg::G_HIGH_ON;
                  state_next.drv.highSideGate = 1'b1;
               end
               else
               begin
                  state_next.gate            = rgp_pkg::G_LOW_ON;
                  state_next.drv.lowSideGate = 1'b1;
               end
            end
            else
            begin
               // opposite gate stays blocked, ramp stays frozen
               state_next.drv.deadTimeFlag = 1'b1;
               state_next.drv.oscFreeze    = 1'b1;
            end
         end
         default:
         begin
            // illegal code: park safely with gates off
            state_next.gate = rgp_pkg::G_OFF;
         end
      endcase

      // every way into the off state drops both gates together
      if (state_next.gate == rgp_pkg::G_OFF)
      begin
         state_next.drv.highSideGate    = 1'b0;
         state_next.drv.lowSideGate     = 1'b0;
         state_next.drv.deadTimeFlag    = 1'b1;
         state_next.drv.oscFreeze       = 1'b0;
         state_next.drv.capacitiveGuard = 1'b0;
      end

      // ***************************************************************
      // overcurrent supervisor
      // ***************************************************************
      unique case (state_reg.oc)
         rgp_pkg::OC_IDLE:
         begin
            if (sense.aboveShutdown)
            begin
               state_next.oc = rgp_pkg::OC_SECOND;
            end
            else if (sense.aboveRegulation)
            begin
               state_next.oc       = rgp_pkg::OC_REG;
               state_next.ocMinCnt = 10'h000;
               events[`RGP_EV_OVERCURRENT] = 1'b1;
            end
         end
         rgp_pkg::OC_REG:
         begin
            // discharge holds at least the minimum time
            if (state_reg.ocMinCnt != OcMinLast)
               state_next.ocMinCnt = state_reg.ocMinCnt + 10'h001;
            if (sense.aboveShutdown)
               state_next.oc = rgp_pkg::OC_SECOND;
            else if (sense.aboveRegulation && sense.timerAboveBoost)
               state_next.oc = rgp_pkg::OC_BOOST;
            else if (!sense.aboveRegulation && state_reg.ocMinCnt == OcMinLast)
               state_next.oc = rgp_pkg::OC_IDLE;
         end
         rgp_pkg::OC_BOOST:
         begin
            // timer keeps rising whatever the current does now
            if (sense.timerAboveStop)
            begin
               state_next.oc = rgp_pkg::OC_STOP;
               events[`RGP_EV_TIMER_STOP] = 1'b1;
            end
         end
         rgp_pkg::OC_STOP:
         begin
            // gates held off while the timer decays, then retry
            if (sense.timerBelowRestart)
               state_next.oc = rgp_pkg::OC_IDLE;
         end
         rgp_pkg::OC_SECOND:
         begin
            // switching goes on; a surge that fades must not latch
            if (!sense.aboveRegulation)
            begin
               state_next.oc = rgp_pkg::OC_IDLE;
            end
            else if (sense.aboveShutdown && sense.ssBelowLatch)
            begin
               state_next.oc = rgp_pkg::OC_LATCH;
               events[`RGP_EV_LATCH] = 1'b1;
            end
         end
         rgp_pkg::OC_LATCH:
         begin
            // only a supply lockout releases the latch
            if (sense.supplyLockout)
               state_next.oc = rgp_pkg::OC_IDLE;
         end
         default:
         begin
            state_next.oc = rgp_pkg::OC_IDLE;
         end
      endcase

      // drives from the next supervisor state, so they leave flops
      ocDischarge = (state_next.oc == rgp_pkg::OC_REG) || (state_next.oc == rgp_pkg::OC_BOOST)
                    || (state_next.oc == rgp_pkg::OC_SECOND) || (state_next.oc == rgp_pkg::OC_STOP);
      state_next.drv.ssDischarge = ocDischarge || state_next.cmpDischarge;
      state_next.drv.timerCharge = (state_next.oc == rgp_pkg::OC_REG)
                                   || (state_next.oc == rgp_pkg::OC_BOOST);
      state_next.drv.latchedOff  = (state_next.oc == rgp_pkg::OC_LATCH);

      // ***************************************************************
      // register port
      // ***************************************************************
      if (regWr)
      begin
         unique case (regAddr)
            `RGP_ADDR_CTRL:   state_next.enable = regWdata[`RGP_CTRL_ENABLE];
            `RGP_ADDR_STATUS: clears = regWdata[3:0];
            `RGP_ADDR_MASK:   state_next.mask = regWdata[3:0];
            default:          ;  // unmapped writes are ignored
         endcase
      end
      if (regRd)
      begin
         unique case (regAddr)
            `RGP_ADDR_CTRL:   state_next.rdata = {31'h0000_0000, state_reg.enable};
            `RGP_ADDR_STATUS: state_next.rdata = {28'h000_0000, state_reg.status};
            `RGP_ADDR_MASK:   state_next.rdata = {28'h000_0000, state_reg.mask};
            `RGP_ADDR_STATE:  state_next.rdata = {19'h0_0000, state_reg.oc, state_reg.gate};
            default:          state_next.rdata = 32'h0000_0000;
         endcase
      end

      // a new event wins over a clear in the same cycle
      state_next.status = (state_reg.status & ~clears) | events;
      state_next.irq    = |(state_next.status & state_next.mask);
   end

   // ******************************************************************
   // state register
   // ******************************************************************
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         state_reg          <= '0;
         state_reg.gate     <= rgp_pkg::G_OFF;
         state_reg.oc       <= rgp_pkg::OC_IDLE;
         state_reg.enable   <= `RGP_CTRL_RESET;
         state_reg.mask     <= `RGP_MASK_RESET;
         state_reg.drv.deadTimeFlag <= 1'b1;
      end
      else if (clkEn)
      begin
         state_reg <= state_next;
      end
   end

endmodule

// ===== verif/rgp_protection_checker.sv
/*
 * Checker of the protection sequencer, watching the top ports only.
 * Assumes the bind at the foot of this file and a 50 MHz mclk.
 */
`timescale 1ns/1ps
module rgp_protection_checker
(
   // clock and reset
   input wire logic                mclk,
   input wire logic                rstn,
   input wire logic                clkEn,
   // power stage
   input wire rgp_pkg::rgp_sense_t sense,
   input wire rgp_pkg::rgp_drive_t drive
);
   logic [11:0] capCnt; // cycles the guard has stood
   logic [11:0] regCnt; // cycles the timer drive has stood

   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // ****************************************
   // helper counters
   // ****************************************
   // saturating, so a stuck output cannot wrap back under a limit
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         capCnt <= 12'h0;
         regCnt <= 12'h0;
      end
      else
      begin
         capCnt <= drive.capacitiveGuard ? capCnt + 12'(~&capCnt) : 12'h0;
         regCnt <= drive.timerCharge ? regCnt + 12'(~&regCnt) : 12'h0;
      end
   end

   // both gates released
   sequence gates_off_s;
      !drive.highSideGate && !drive.lowSideGate;
   endsequence
   // first-level drives both on
   sequence oc_drive_s;
      drive.timerCharge && drive.ssDischarge;
   endsequence

   gate_interlock_a:
   assert property (!(drive.highSideGate && drive.lowSideGate)) else $error("both gates on");
   guard_dead_a:
   assert property (drive.capacitiveGuard |-> (drive.deadTimeFlag && drive.oscFreeze) ##0 gates_off_s)
      else $error("guard without dead time or frozen ramp");
   guard_slew_a:
   assert property (drive.capacitiveGuard && !sense.slewSense && capCnt < 12'h960 |=> gates_off_s)
      else $error("gate on without slew");
   guard_timeout_a:
   assert property (capCnt <= 12'h9C9) else $error("polarity wait overran");
   reg_entry_a:
   assert property (!drive.timerCharge && !drive.ssDischarge && !drive.latchedOff && sense.aboveRegulation
      && !sense.aboveShutdown && !sense.supplyLockout && clkEn |=> oc_drive_s) else $error("no discharge");
   reg_min_a:
   assert property ($fell(drive.timerCharge) && $fell(drive.ssDischarge) && $past(clkEn)
      && !$past(sense.supplyLockout) |-> regCnt >= 12'h1F4) else $error("discharge too short");
   stop_off_a:
   assert property (drive.timerCharge && sense.aboveRegulation && sense.timerAboveBoost && sense.timerAboveStop
      && !sense.aboveShutdown && clkEn |-> ##[1:4] gates_off_s) else $error("no stop at stop level");
   latch_off_a:
   assert property (drive.latchedOff |=> gates_off_s) else $error("gate on while latched");
   latch_hold_a:
   assert property (drive.latchedOff && !sense.supplyLockout |=> drive.latchedOff) else $error("latch lost");
endmodule

bind rgp_protection rgp_protection_checker i_chk
   (.mclk(mclk), .rstn(rstn), .clkEn(clkEn), .sense(sense), .drive(drive));

// ===== verif/rgp_bridge_model.sv
/*
 * Half-bridge and current sense: 20-cycle half periods, slew after
 * 3 dead cycles, polarity from the last gate on.
 * Assumes the bench drives the overcurrent and timer levels on ocIn.
 */
`timescale 1ns/1ps
module rgp_bridge_model
(
   // clock and reset
   input wire logic                mclk,
   input wire logic                rstn,
   // drives and bench controls
   input wire rgp_pkg::rgp_drive_t drive,
   input wire logic                wrongPol,
   input wire rgp_pkg::rgp_sense_t ocIn,
   // sensed levels
   output rgp_pkg::rgp_sense_t     sense
);
   logic [4:0] halfCnt; // cycles the present gate has been on
   logic [1:0] offCnt;  // dead cycles, saturating
   logic       lastLow; // low side was the last gate on

   // ****************************************
   // oscillator and tank
   // ****************************************
   // the ramp only runs while a gate conducts and nothing freezes it
   always_ff @(posedge mclk)
   begin
      if (!rstn || drive.oscFreeze || !(drive.highSideGate || drive.lowSideGate))
         halfCnt <= 5'h0;
      else
         halfCnt <= halfCnt + 5'h1;
      offCnt <= (!rstn || drive.highSideGate || drive.lowSideGate) ? 2'h0 : offCnt + 2'(~&offCnt);
      lastLow <= rstn && (drive.lowSideGate || (lastLow && !drive.highSideGate));
   end

   // wrong polarity means no usable current: no flag and no slew
   always_comb
   begin
      sense = ocIn;
      sense.negRefBelow = lastLow && !wrongPol;
      sense.posRefAbove = !lastLow && !wrongPol;
      sense.slewSense = (offCnt == 2'h3) && !wrongPol;
      sense.oscHalfEnd = (halfCnt == 5'h13);
   end
endmodule

// ===== verif/rgp_protection_tb.sv
/*
 * Self-checking bench of the protection sequencer.
 * Assumes the bridge model as power stage and the bound checker.
 */
`timescale 1ns/1ps
`include "rgp_defines.svh"
module rgp_protection_tb;
   // bundle bit positions
   localparam int HSG = 7, LSG = 6, SSD = 3, TMC = 2, LAT = 1, CAPG = 0;
   localparam int AREG = 8, ASHD = 7, TBST = 6, TSTP = 5, TRST = 4, SLAT = 3, LOCK = 1;
   logic                mclk, rstn, clkEn, regWr, regRd, irq, wrongPol;
   logic [3:0]          regAddr;
   logic [31:0]         regWdata, regRdata;
   rgp_pkg::rgp_sense_t sense, ocIn;
   rgp_pkg::rgp_drive_t drive;
   int                  n_errors, comparisons, cnt;

   rgp_protection i_dut (.mclk(mclk), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sense(sense), .drive(drive), .irq(irq));
   rgp_bridge_model i_bridge (.mclk(mclk), .rstn(rstn), .drive(drive), .wrongPol(wrongPol), .ocIn(ocIn),
      .sense(sense));

   // ****************************************
   // bus and compare tasks
   // ****************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chkbit(input int idx, input logic v);
      chk(32'(drive[idx]), 32'(v));
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      {regWr, regAddr, regWdata} <= {1'h1, a, d};
      @(posedge mclk);
      regWr <= 1'h0;
   endtask
   // read data stand only in the cycle after the strobe
   task rdchk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge mclk);
      {regRd, regAddr} <= {1'h1, a};
      @(posedge mclk);
      regRd <= 1'h0;
      @(negedge mclk);
      chk(regRdata, exp);
   endtask
   // bounded wait on one drive bit, sampled away from the edge
   task waitd(input int idx, input logic v, input int lim);
      cnt = 0;
      @(negedge mclk);
      while (drive[idx] !== v && cnt < lim)
      begin
         @(negedge mclk);
         cnt++;
      end
      chkbit(idx, v);
   endtask
   task so(input int idx, input logic v);
      @(posedge mclk);
      ocIn[idx] <= v;
   endtask
   task setpol(input logic v);
      @(posedge mclk);
      wrongPol <= v;
   endtask
   // next low-side turn-off with wrong polarity
   task capin();
      waitd(LSG, 1'h0, 60);
      waitd(LSG, 1'h1, 60);
      setpol(1'h1);
      waitd(CAPG, 1'h1, 60);
   endtask
   task final_report();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end
   // watchdog: the tests need under 8000 cycles
   initial
   begin
      repeat (50000) @(posedge mclk);
      n_errors++;
      final_report();
   end

   initial
   begin
      {rstn, regWr, regRd, wrongPol, regAddr, regWdata} = '0;
      clkEn = 1'h1;
      ocIn = 11'h010; // timer ramp idles below its restart level
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk(32'(drive), 32'h20);
      @(posedge mclk);
      rstn <= 1'h1;
      rdchk(`RGP_ADDR_CTRL, 32'h1);
      rdchk(`RGP_ADDR_MASK, 32'h0);
      wr(4'h2, 32'hFFFF_FFFF);
      rdchk(4'h2, 32'h0);
      waitd(HSG, 1'h1, 100);
      waitd(LSG, 1'h1, 100);
      rdchk(`RGP_ADDR_STATUS, 32'h0);
      // capacitive turn-off of the low side, recovered by polarity
      wr(`RGP_ADDR_MASK, 32'h1);
      capin();
      chk(32'(drive[7:4]), 32'h3);
      chk(32'(irq), 32'h1);
      repeat (70) @(negedge mclk);
      chkbit(SSD, 1'h0);
      repeat (10) @(negedge mclk);
      chkbit(SSD, 1'h1);
      chkbit(HSG, 1'h0);
      setpol(1'h0);
      waitd(HSG, 1'h1, 8);
      waitd(LSG, 1'h1, 60);
      chkbit(SSD, 1'h1);
      waitd(LSG, 1'h0, 30);
      repeat (2) @(negedge mclk);
      chkbit(SSD, 1'h0);
      rdchk(`RGP_ADDR_STATUS, 32'h1);
      wr(`RGP_ADDR_STATUS, 32'h1);
      @(negedge mclk);
      chk(32'(irq), 32'h0);
      // polarity never recovers: forced on, event masked
      wr(`RGP_ADDR_MASK, 32'h0);
      capin();
      waitd(HSG, 1'h1, 2600);
      chk(32'(cnt > 2490 && cnt < 2510), 32'h1);
      chk(32'(irq), 32'h0);
      setpol(1'h0);
      wr(`RGP_ADDR_STATUS, 32'hF);
      // first level, current drops early
      waitd(SSD, 1'h0, 200);
      so(AREG, 1'h1);
      waitd(TMC, 1'h1, 4);
      chkbit(SSD, 1'h1);
      repeat (50) @(negedge mclk);
      so(AREG, 1'h0);
      repeat (400) @(negedge mclk);
      chkbit(SSD, 1'h1);
      waitd(SSD, 1'h0, 100);
      chkbit(TMC, 1'h0);
      // persistent first level: two hiccups
      wr(`RGP_ADDR_MASK, 32'h4);
      for (int i = 0; i < 2; i++)
      begin
         so(AREG, 1'h1);
         so(TRST, 1'h0);
         so(TBST, 1'h1);
         so(TSTP, 1'h1);
         waitd(TMC, 1'h0, 8);
         repeat (2) @(negedge mclk);
         chk(32'(drive[7:6]), 32'h0);
         chkbit(SSD, 1'h1);
         chk(32'(irq), 32'h1);
         so(AREG, 1'h0);
         so(TBST, 1'h0);
         so(TSTP, 1'h0);
         repeat (100) @(negedge mclk);
         chk(32'(drive[7:6]), 32'h0);
         so(TRST, 1'h1);
         waitd(LSG, 1'h1, 10);
         chkbit(LAT, 1'h0);
         wr(`RGP_ADDR_STATUS, 32'hF);
      end
      // second level abandoned, then latched
      so(AREG, 1'h1);
      so(ASHD, 1'h1);
      waitd(HSG, 1'h1, 60);
      waitd(HSG, 1'h0, 60);
      chkbit(SSD, 1'h1);
      so(ASHD, 1'h0);
      so(AREG, 1'h0);
      waitd(SSD, 1'h0, 6);
      chkbit(LAT, 1'h0);
      so(AREG, 1'h1);
      so(ASHD, 1'h1);
      so(SLAT, 1'h1);
      waitd(LAT, 1'h1, 8);
      so(ASHD, 1'h0);
      so(AREG, 1'h0);
      repeat (50) @(negedge mclk);
      chk(32'(drive[7:6]), 32'h0);
      chkbit(LAT, 1'h1);
      so(LOCK, 1'h1);
      so(SLAT, 1'h0);
      so(LOCK, 1'h0);
      waitd(LAT, 1'h0, 4);
      waitd(LSG, 1'h1, 60);
      final_report();
   end
endmodule
